/* File: include/ipr_map.vh */
// Purpose: Register map, field positions and reset values of the
//          interrupt priority and return block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Definitions only; included by bare name.
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// Register byte offsets
`define IPR_OFS_FLAG 6'h00
`define IPR_OFS_ENABLE 6'h04
`define IPR_OFS_PRIO0 6'h08
`define IPR_OFS_CTRL1 6'h18
`define IPR_OFS_CTRL2 6'h1c
`define IPR_OFS_STATUS 6'h20
`define IPR_OFS_CORE 6'h24
`define IPR_OFS_VECTOR 6'h28

// Field positions
`define IPR_NEST_BIT 15
`define IPR_ALT_BIT 15
`define IPR_PRIO_LSB 5
`define IPR_PRIO_MSB 7
`define IPR_HIGH_BIT 3
`define IPR_VEC_MSB 6
`define IPR_LVL_LSB 8
`define IPR_LVL_MSB 11
`define IPR_PRIO_SLOTS 4
`define IPR_SLOT_W 4

// Encodings and reset values
`define IPR_LEVEL_MASKED 3'h7
`define IPR_RST_LEVEL 4'h0
`define IPR_RST_PRIO 3'h0
`define IPR_RST_WORD 16'h0000
`define IPR_WAIT_IDLE 1'b0

// Return sequence states
`define IPR_RS_IDLE 3'h0
`define IPR_RS_POP1 3'h1
`define IPR_RS_POP2 3'h2
`define IPR_RS_FETCH 3'h3
`define IPR_RS_RESUME 3'h4

`endif

/* File: verilog/ipr_arbiter.v */
// Purpose: Picks the highest-priority pending, enabled source.
// Assumes: Flags, enables and 3-bit levels come from registers.
// Notes:   Ties go to the lowest source number.
`timescale 1ns/100ps
module ipr_arbiter
#(
    parameter NSRC = 16
)
(
    // Source state
    input wire [NSRC-1:0] flags,
    input wire [NSRC-1:0] enables,
    input wire [NSRC*3-1:0] levels,
    // Winner
    output reg anyReq,
    output reg [6:0] bestVec,
    output reg [2:0] bestLvl
);

integer i;

// Scan from the top down so an equal level at a lower number wins
always @*
begin
    anyReq = 1'b0;
    bestVec = 7'h00;
    bestLvl = 3'h0;
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
        if (flags[i] && enables[i] &&
            (!anyReq || levels[i*3 +: 3] >= bestLvl))
        begin
            anyReq = 1'b1;
            bestVec = i[6:0];
            bestLvl = levels[i*3 +: 3];
        end
    end
end

endmodule // ipr_arbiter

/* File: verilog/ipr_ret_seq.v */
// Purpose: Four-cycle return-from-interrupt sequencer.
// Assumes: cyEn marks one instruction cycle; retExec is sampled on it.
// Notes:   Cycles one and two pop, three fetches as a no-op, four resumes.
`timescale 1ns/100ps
module ipr_ret_seq
(
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Cycle timing and trigger
    input wire cyEn,
    input wire retExec,
    // Sequence outputs
    output wire seqIdle,
    output reg popStrobe,
    output wire restoreNow,
    output reg fetchNop,
    output reg resumeNow
);

`include "ipr_map.vh"

reg [2:0] state;
reg [2:0] next_state;

// Status byte and level come back at the end of the second pop
assign restoreNow = cyEn && (state == `IPR_RS_POP2);
assign seqIdle = (state == `IPR_RS_IDLE);

// Next state, one step per instruction cycle
always @*
begin
    next_state = state;
    case (state)
        `IPR_RS_IDLE:
            if (retExec)
                next_state = `IPR_RS_POP1;
        `IPR_RS_POP1:
            next_state = `IPR_RS_POP2;
        `IPR_RS_POP2:
            next_state = `IPR_RS_FETCH;
        `IPR_RS_FETCH:
            next_state = `IPR_RS_RESUME;
        `IPR_RS_RESUME:
            next_state = `IPR_RS_IDLE;
        default:
            next_state = `IPR_RS_IDLE;
    endcase
end

// State and per-cycle indications
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        state <= `IPR_RS_IDLE;
        popStrobe <= 1'b0;
        fetchNop <= 1'b0;
        resumeNow <= 1'b0;
    end
    else if (cyEn)
    begin
        state <= next_state;
        popStrobe <= (next_state == `IPR_RS_POP1) ||
                     (next_state == `IPR_RS_POP2);
        fetchNop <= (next_state == `IPR_RS_FETCH);
        resumeNow <= (next_state == `IPR_RS_RESUME);
    end
end

endmodule // ipr_ret_seq

/* File: verilog/ipr_core.v */
// Purpose: Interrupt priority selection, CPU level and return sequencing.
// Assumes: Source events and core signals are on clk_sys.
// Notes:   Registers reached over Avalon-MM, one wait state per access.
//
// Behaviour
// - Return pops PC and status byte, cycles 1-2
// - Return cycle 3 fetches, runs as no-op
// - Return cycle 4 resumes interrupted program
// - Entry waits for instruction end, fixed latency
// - Listed stall conditions add one entry cycle
// - Per-source flag, hardware sets, software clears
// - Per-source enable bit gates each source
// - Each source gets one of eight levels
// - CPU level is status bits 7:5, writable
// - Fourth level bit is read-only to software
// - Latch vector number and new level
// - Sources map to bits in vector order
// - Level field binary; 111 masks user sources
// - Fourth bit above field; set masks users
// - Level field read-only while nesting disabled
// - Fourth bit shows level above 7, resets 0
// - Request only if level exceeds CPU level
// - Nesting disabled forces level 7 on entry
// - Alternate table select picks vector table
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module ipr_core
#(
    parameter NSRC = 16,
    parameter CYC_DIV = 4
)
(
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Request sources
    input wire [NSRC-1:0] srcEvent,
    // Core sequencer
    input wire instrDone,
    input wire entryStall,
    input wire retExec,
    input wire [7:0] stackStatusLow,
    input wire stackHighBit,
    input wire trapEnter,
    input wire [3:0] trapLevel,
    // To core
    output reg cycleTick,
    output reg irqPending,
    output reg entryStart,
    output reg [6:0] entryVector,
    output reg useAltTable,
    output wire [3:0] cpuLevel,
    output wire retPop,
    output wire retFetchNop,
    output wire retResume
);

`include "ipr_map.vh"

localparam NPRIO = NSRC / `IPR_PRIO_SLOTS;

////////////////////////////////////////////////////////////////////////
// Functions
// Merge a 16-bit write under its two low byte enables
function [15:0] merge;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0] be;
    begin
        merge = old;
        if (be[0])
            merge[7:0] = wdat[7:0];
        if (be[1])
            merge[15:8] = wdat[15:8];
    end
endfunction

// Byte offset of priority register k
function [5:0] prioOfs;
    input integer k;
    begin
        prioOfs = `IPR_OFS_PRIO0 + k[3:0] * 6'h04;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Storage
reg [NSRC-1:0] flagReg;
reg [NSRC-1:0] enableReg;
reg [NSRC*3-1:0] prioReg;
reg nestDisable;
reg altSelect;
reg [2:0] cpuPrio;
reg highBit;
reg [6:0] vecLatch;
reg [3:0] lvlLatch;
reg busAck;
reg delayOne;
reg [7:0] divCnt;

wire anyReq;
wire [6:0] bestVec;
wire [2:0] bestLvl;
wire seqIdle;
wire restoreNow;
wire busReq;
wire wrNow;
wire pendReq;
wire [15:0] wdat;
wire [1:0] wbe;

assign cpuLevel = {highBit, cpuPrio};
assign busReq = avs_read || avs_write;
// A single wait state keeps the decode and read mux off the bus path
assign avs_waitrequest = busReq && !busAck;
assign wrNow = avs_write && busAck;
assign wdat = avs_writedata[15:0];
assign wbe = avs_byteenable[1:0];

////////////////////////////////////////////////////////////////////////
// Selection
ipr_arbiter
#(
    .NSRC(NSRC)
)
uArb
(
    .flags(flagReg),
    .enables(enableReg),
    .levels(prioReg),
    .anyReq(anyReq),
    .bestVec(bestVec),
    .bestLvl(bestLvl)
);

// Strict compare; the high bit or field 111 leaves no user level above
assign pendReq = anyReq && ({1'b0, bestLvl} > cpuLevel);
ipr_ret_seq uRet
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cyEn(cycleTick),
    .retExec(retExec),
    .seqIdle(seqIdle),
    .popStrobe(retPop),
    .restoreNow(restoreNow),
    .fetchNop(retFetchNop),
    .resumeNow(retResume)
);

////////////////////////////////////////////////////////////////////////
// Instruction cycle divider
// One tick per instruction cycle, all sequencing steps on it
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        divCnt <= 8'h00;
        cycleTick <= 1'b0;
    end
    else if (divCnt == CYC_DIV[7:0] - 8'h01)
    begin
        divCnt <= 8'h00;
        cycleTick <= 1'b1;
    end
    else
    begin
        divCnt <= divCnt + 8'h01;
        cycleTick <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Bus handshake
// Ack drops after each answered beat so back-to-back requests wait again
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
        busAck <= `IPR_WAIT_IDLE;
    else
        busAck <= busReq && !busAck;
end

////////////////////////////////////////////////////////////////////////
// Flags, enables, priorities and controls
integer k;
integer j;
integer m;
integer n;
// A source event in the clearing cycle survives the clear
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
        flagReg <= {NSRC{1'b0}};
    else if (wrNow && avs_address == `IPR_OFS_FLAG)
        flagReg <= (flagReg & ~merge(16'h0000, wdat, wbe)) |
                   srcEvent;
    else
        flagReg <= flagReg | srcEvent;
end

// Enables, priority fields and the two control bits
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        enableReg <= {NSRC{1'b0}};
        prioReg <= {NSRC*3{1'b0}};
        nestDisable <= 1'b0;
        altSelect <= 1'b0;
    end
    else if (wrNow)
    begin
        if (avs_address == `IPR_OFS_ENABLE)
            enableReg <= merge(enableReg, wdat, wbe);
        if (avs_address == `IPR_OFS_CTRL1 && wbe[1])
            nestDisable <= wdat[`IPR_NEST_BIT];
        if (avs_address == `IPR_OFS_CTRL2 && wbe[1])
            altSelect <= wdat[`IPR_ALT_BIT];
        for (k = 0; k < NPRIO; k = k + 1)
        begin
            if (avs_address == prioOfs(k))
            begin
                for (j = 0; j < `IPR_PRIO_SLOTS; j = j + 1)
                begin
                    if (wbe[j/2])
                        prioReg[(k*`IPR_PRIO_SLOTS+j)*3 +: 3] <=
                            wdat[j*`IPR_SLOT_W +: 3];
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// CPU priority level
// Trap entry outranks a return restore, which outranks user entry
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        cpuPrio <= `IPR_RST_PRIO;
        highBit <= 1'b0;
    end
    else if (trapEnter)
    begin
        cpuPrio <= trapLevel[2:0];
        highBit <= trapLevel[3];
    end
    else if (restoreNow)
    begin
        cpuPrio <= stackStatusLow[`IPR_PRIO_MSB:`IPR_PRIO_LSB];
        highBit <= stackHighBit;
    end
    else if (entryStart)
    begin
        cpuPrio <= nestDisable ? `IPR_LEVEL_MASKED : lvlLatch[2:0];
        highBit <= 1'b0;
    end
    else if (wrNow && avs_address == `IPR_OFS_STATUS && wbe[0] &&
             !nestDisable)
        cpuPrio <= wdat[`IPR_PRIO_MSB:`IPR_PRIO_LSB];
end

////////////////////////////////////////////////////////////////////////
// Interrupt entry
// Entry is judged only at an instruction boundary; a flagged stall
// costs exactly one more cycle and the request is judged again then
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        delayOne <= 1'b0;
        entryStart <= 1'b0;
        vecLatch <= 7'h00;
        lvlLatch <= `IPR_RST_LEVEL;
        entryVector <= 7'h00;
        irqPending <= 1'b0;
        useAltTable <= 1'b0;
    end
    else
    begin
        irqPending <= pendReq;
        useAltTable <= altSelect;
        entryStart <= 1'b0;
        if (cycleTick && seqIdle && !trapEnter && !retExec)
        begin
            if (delayOne)
            begin
                delayOne <= 1'b0;
                if (pendReq)
                begin
                    entryStart <= 1'b1;
                    vecLatch <= bestVec;
                    lvlLatch <= {1'b0, bestLvl};
                    entryVector <= bestVec;
                end
            end
            else if (instrDone && pendReq)
            begin
                if (entryStall)
                    delayOne <= 1'b1;
                else
                begin
                    entryStart <= 1'b1;
                    vecLatch <= bestVec;
                    lvlLatch <= {1'b0, bestLvl};
                    entryVector <= bestVec;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read data
// Captured on the wait cycle so it stands at the answering edge
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
        avs_readdata <= 32'h00000000;
    else if (avs_read && !busAck)
    begin
        avs_readdata <= 32'h00000000;
        case (avs_address)
            `IPR_OFS_FLAG:
                avs_readdata[NSRC-1:0] <= flagReg;
            `IPR_OFS_ENABLE:
                avs_readdata[NSRC-1:0] <= enableReg;
            `IPR_OFS_CTRL1:
                avs_readdata[`IPR_NEST_BIT] <= nestDisable;
            `IPR_OFS_CTRL2:
                avs_readdata[`IPR_ALT_BIT] <= altSelect;
            `IPR_OFS_STATUS:
                avs_readdata[`IPR_PRIO_MSB:`IPR_PRIO_LSB] <= cpuPrio;
            `IPR_OFS_CORE:
                avs_readdata[`IPR_HIGH_BIT] <= highBit;
            `IPR_OFS_VECTOR:
            begin
                avs_readdata[`IPR_VEC_MSB:0] <= vecLatch;
                avs_readdata[`IPR_LVL_MSB:`IPR_LVL_LSB] <= lvlLatch;
            end
            default:
            begin
                for (m = 0; m < NPRIO; m = m + 1)
                begin
                    if (avs_address == prioOfs(m))
                    begin
                        for (n = 0; n < `IPR_PRIO_SLOTS; n = n + 1)
                            avs_readdata[n*`IPR_SLOT_W +: 3] <=
                                prioReg[(m*`IPR_PRIO_SLOTS+n)*3 +: 3];
                    end
                end
            end
        endcase
    end
end

endmodule // ipr_core

/* File: tb/ipr_core_props.sv */
// Purpose: Port timing checks for the priority and return block
// Assumes: Bound to ipr_core; CYC_DIV is handed on by the bind
// Notes:   Register contents are judged by the bench, not here
`timescale 1ns/100ps
module ipr_core_props
#(
    parameter CYC_DIV = 4
)
(
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Bus
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Core side
    input wire retExec,
    input wire trapEnter,
    input wire cycleTick,
    input wire irqPending,
    input wire entryStart,
    input wire [3:0] cpuLevel,
    input wire retPop,
    input wire retFetchNop,
    input wire retResume
);
    localparam int CD = CYC_DIV;
    localparam int CDM = CYC_DIV - 1;
    logic [7:0] popLen;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // Pop phase length, zero while idle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            popLen <= 8'h00;
        else
            popLen <= retPop ? popLen + 8'h01 : 8'h00;
    end
    // Cycle three is a no-op fetch, cycle four resumes
    sequence tailSeq;
        retFetchNop && !retResume ##CD retResume && !retFetchNop
            ##CD !retResume;
    endsequence
    wait_one_a: assert property ($rose(avs_read || avs_write) |-> // CONTRACT
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait state");
    read_upper_a: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    entry_pulse_a: assert property (entryStart |=> !entryStart)
        else $error("entry pulse longer than one clock");
    entry_tick_a: assert property (entryStart |-> $past(cycleTick))
        else $error("entry not aligned to an instruction cycle");
    entry_level_a: assert property (entryStart && !trapEnter |=>
        cpuLevel > $past(cpuLevel) && !cpuLevel[3])
        else $error("entry did not raise the level");
    ret_start_a: assert property ($rose(retPop) |->
        $past(retExec && cycleTick))
        else $error("pop without a taken return");
    pop_len_a: assert property ($fell(retPop) |-> popLen == 2 * CD)
        else $error("pop phase not two instruction cycles");
    ret_tail_a: assert property ($fell(retPop) |-> tailSeq)
        else $error("fetch and resume cycles out of order");
    tick_period_a: assert property (cycleTick |=>
        !cycleTick ##CDM cycleTick)
        else $error("instruction cycle length wrong");
    high_mask_a: assert property (cpuLevel[3] && $past(cpuLevel[3])
        |-> !irqPending)
        else $error("user request shown above level 7");
    no_entry_ret_a: assert property (retPop || retFetchNop |-> !entryStart)
        else $error("entry during return sequence");
    irq_shown_a: assert property (entryStart |-> irqPending)
        else $error("entry without a shown pending request");
endmodule // ipr_core_props

bind ipr_core ipr_core_props #(.CYC_DIV(CYC_DIV)) props_u (.clk_sys,
    .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .retExec, .trapEnter, .cycleTick, .irqPending, .entryStart, .cpuLevel,
    .retPop, .retFetchNop, .retResume);

/* File: tb/ipr_cpu_model.sv */
// Purpose: Behavioural CPU sequencer facing the priority block
// Assumes: One saved level is enough; the bench never nests
// Notes:   slow makes every instruction take two cycles
`timescale 1ns/100ps
module ipr_cpu_model
(
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Bench controls
    input wire doRet,
    input wire slow,
    // From the block
    input wire cycleTick,
    input wire entryStart,
    input wire [3:0] cpuLevel,
    // To the block
    output reg instrDone,
    output reg retExec,
    output wire [7:0] stackStatusLow,
    output wire stackHighBit
);
    reg [3:0] savedLevel;
    ////////////////////////////////////////////////////////////
    // Popped status byte carries the level field only
    assign stackStatusLow = {savedLevel[2:0], 5'h00};
    assign stackHighBit = savedLevel[3];
    // Push on entry, hold return until an instruction cycle takes it
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            savedLevel <= 4'h0;
            instrDone <= 1'b1;
            retExec <= 1'b0;
        end
        else
        begin
            if (entryStart)
                savedLevel <= cpuLevel;
            if (cycleTick)
                instrDone <= slow ? !instrDone : 1'b1;
            if (cycleTick && retExec)
                retExec <= 1'b0;
            else if (doRet)
                retExec <= 1'b1;
        end
    end
endmodule // ipr_cpu_model

/* File: tb/test_interrupt_priority_return.sv */
// Purpose: Self-checking bench for the priority and return block
// Assumes: CYC_DIV of 2 keeps instruction cycles short
// Notes:   Table rows cover arbitration; hand tests follow
`timescale 1ns/100ps
`include "ipr_map.vh"
module test_interrupt_priority_return;
    localparam CD = 2;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [5:0] avs_address = 6'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avsBe = 4'h3;
    reg [15:0] srcEvent = 16'h0;
    reg entryStall = 1'b0;
    reg trapEnter = 1'b0;
    reg [3:0] trapLevel = 4'h0;
    reg doRet = 1'b0;
    reg slow = 1'b0;
    wire [31:0] avs_readdata;
    wire [7:0] stackStatusLow;
    wire [6:0] entryVector;
    wire [3:0] cpuLevel;
    wire avs_waitrequest, instrDone, retExec, stackHighBit, cycleTick;
    wire irqPending, entryStart, useAltTable, retPop, retFetchNop;
    wire retResume;
    integer numErrors = 0;
    integer nCompared = 0;
    integer cycles = 0;
    integer r;
    reg [34:0] rows [0:5];
    reg [15:0] d;
    reg seen;
    ////////////////////////////////////////////////////////////
    ipr_core #(.NSRC(16), .CYC_DIV(CD)) dut_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avsBe), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .srcEvent(srcEvent),
        .instrDone(instrDone), .entryStall(entryStall), .retExec(retExec),
        .stackStatusLow(stackStatusLow), .stackHighBit(stackHighBit),
        .trapEnter(trapEnter), .trapLevel(trapLevel),
        .cycleTick(cycleTick), .irqPending(irqPending),
        .entryStart(entryStart), .entryVector(entryVector),
        .useAltTable(useAltTable), .cpuLevel(cpuLevel), .retPop(retPop),
        .retFetchNop(retFetchNop), .retResume(retResume));
    ipr_cpu_model cpu_u (.clk_sys(clk_sys), .rst_n(rst_n), .doRet(doRet),
        .slow(slow), .cycleTick(cycleTick), .entryStart(entryStart),
        .cpuLevel(cpuLevel), .instrDone(instrDone), .retExec(retExec),
        .stackStatusLow(stackStatusLow), .stackHighBit(stackHighBit));
    // Clock, and a cycle ceiling so a hang still reaches the verdict
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            numErrors = numErrors + 1;
            wrapUp;
        end
    end
    task chk(input [31:0] seenVal, input [31:0] expVal);
    begin
        nCompared = nCompared + 1;
        if (seenVal !== expVal)
        begin
            numErrors = numErrors + 1;
            $display("FAIL at %0t: got %h expected %h", $time, seenVal,
                expVal);
        end
    end
    endtask
    // Bus cycles hold the request until waitrequest is seen low
    task busWr(input [5:0] a, input [15:0] v);
    begin
        avs_address <= a;
        avs_writedata <= {16'h0000, v};
        avs_write <= 1'b1;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    end
    endtask
    task busRd(input [5:0] a, output [15:0] v);
    begin
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        v = avs_readdata[15:0];
        avs_read <= 1'b0;
        @(posedge clk_sys);
    end
    endtask
    // Pulse source events, then watch a bounded time for entry
    task raiseWait(input [15:0] ev);
        integer i;
    begin
        srcEvent <= ev;
        @(posedge clk_sys);
        srcEvent <= 16'h0000;
        seen = 1'b0;
        for (i = 0; i < 40 && !seen; i = i + 1)
        begin
            @(posedge clk_sys);
            seen = (entryStart === 1'b1);
        end
        @(posedge clk_sys);
    end
    endtask
    task doReturn;
        integer i;
        reg gotRes;
        reg done;
    begin
        gotRes = 1'b0;
        done = 1'b0;
        doRet <= 1'b1;
        @(posedge clk_sys);
        doRet <= 1'b0;
        for (i = 0; i < 60 && !done; i = i + 1)
        begin
            @(posedge clk_sys);
            if (retResume === 1'b1)
                gotRes = 1'b1;
            else if (gotRes)
                done = 1'b1;
        end
        chk(done, 1'b1);
    end
    endtask
    task wrapUp;
    begin
        $display("Compared %0d values, %0d mismatches", nCompared,
            numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////
    // Rows: events, enables, priority word, vector held, level (0 = none)
    initial
    begin
        rows[0] = {4'h1, 4'h1, 16'h0003, 7'h00, 4'h3};
        rows[1] = {4'h6, 4'h6, 16'h0350, 7'h01, 4'h5};
        rows[2] = {4'hc, 4'hc, 16'h4400, 7'h02, 4'h4};
        rows[3] = {4'h3, 4'h2, 16'h0017, 7'h01, 4'h1};
        rows[4] = {4'h1, 4'h1, 16'h0000, 7'h01, 4'h0};
        rows[5] = {4'h8, 4'h8, 16'h7000, 7'h03, 4'h7};
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        for (r = 0; r < 6; r = r + 1)
        begin
            busWr(`IPR_OFS_ENABLE, {12'h000, rows[r][30:27]});
            busWr(`IPR_OFS_PRIO0, rows[r][26:11]);
            raiseWait({12'h000, rows[r][34:31]});
            chk(seen, rows[r][3:0] != 4'h0);
            chk(entryVector, rows[r][10:4]);
            chk(cpuLevel, rows[r][3:0]);
            busRd(`IPR_OFS_VECTOR, d);
            if (seen)
                chk(d[11:0], {rows[r][3:0], 1'b0, rows[r][10:4]});
            busRd(`IPR_OFS_FLAG, d);
            chk(d, {12'h000, rows[r][34:31]});
            busWr(`IPR_OFS_FLAG, 16'h000f);
            busRd(`IPR_OFS_FLAG, d);
            chk(d, 16'h0000);
            if (seen)
                doReturn;
            chk(cpuLevel, 4'h0);
            $display("row %0d done", r);
        end
        // Read-only high bit, unmapped place, level 7 masking
        busWr(`IPR_OFS_CORE, 16'h0008);
        busRd(`IPR_OFS_CORE, d);
        chk(d, 16'h0000);
        busRd(6'h3c, d);
        chk(d, 16'h0000);
        avsBe <= 4'h2;
        busWr(`IPR_OFS_STATUS, 16'h00e0);
        busRd(`IPR_OFS_STATUS, d);
        chk(d, 16'h0000);
        avsBe <= 4'h3;
        busWr(`IPR_OFS_STATUS, 16'h00e0);
        busRd(`IPR_OFS_STATUS, d);
        chk(d, 16'h00e0);
        busWr(`IPR_OFS_ENABLE, 16'h0001);
        busWr(`IPR_OFS_PRIO0, 16'h0007);
        raiseWait(16'h0001);
        chk(seen, 1'b0);
        busWr(`IPR_OFS_STATUS, 16'h0000);
        raiseWait(16'h0000);
        chk(seen, 1'b1);
        chk(cpuLevel, 4'h7);
        busWr(`IPR_OFS_FLAG, 16'h0001);
        doReturn;
        $display("test masking done");
        // Nesting disabled, two-cycle instructions with a stall
        busWr(`IPR_OFS_CTRL1, 16'h8000);
        busWr(`IPR_OFS_STATUS, 16'h0040);
        busRd(`IPR_OFS_STATUS, d);
        chk(d, 16'h0000);
        slow <= 1'b1;
        entryStall <= 1'b1;
        busWr(`IPR_OFS_PRIO0, 16'h0020);
        busWr(`IPR_OFS_ENABLE, 16'h0002);
        raiseWait(16'h0002);
        chk(seen, 1'b1);
        chk(cpuLevel, 4'h7);
        busWr(`IPR_OFS_FLAG, 16'h0002);
        doReturn;
        chk(cpuLevel, 4'h0);
        busWr(`IPR_OFS_CTRL1, 16'h0000);
        slow <= 1'b0;
        entryStall <= 1'b0;
        busWr(`IPR_OFS_CTRL2, 16'h8000);
        repeat (2) @(posedge clk_sys);
        chk(useAltTable, 1'b1);
        busWr(`IPR_OFS_CTRL2, 16'h0000);
        $display("test nesting done");
        // Trap level masks users; reset in mid-run clears it
        trapLevel <= 4'hc;
        trapEnter <= 1'b1;
        @(posedge clk_sys);
        trapEnter <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(cpuLevel, 4'hc);
        busRd(`IPR_OFS_CORE, d);
        chk(d, 16'h0008);
        busRd(`IPR_OFS_STATUS, d);
        chk(d, 16'h0080);
        busWr(`IPR_OFS_PRIO0, 16'h0007);
        busWr(`IPR_OFS_ENABLE, 16'h0001);
        raiseWait(16'h0001);
        chk(seen, 1'b0);
        chk(irqPending, 1'b0);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(cpuLevel, 4'h0);
        busRd(`IPR_OFS_CORE, d);
        chk(d, 16'h0000);
        busRd(`IPR_OFS_FLAG, d);
        chk(d, 16'h0000);
        $display("test trap and reset done");
        wrapUp;
    end
endmodule // test_interrupt_priority_return
